/* File: src/buffered_compare_timer_core.sv */
// Sixteen-bit timer core with double-buffered period and three compare channels.
// Assumes a plain register port on clk and pin data from the port block on clk.
`timescale 1ns/1ps
module buffered_compare_timer_core (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [timer_core_pkg::ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  input wire logic event_in,
  input wire logic [timer_core_pkg::CHANNELS-1:0] port_out_value,
  output logic [timer_core_pkg::CHANNELS-1:0] pin_out,
  output logic [timer_core_pkg::CHANNELS-1:0] pin_override,
  output logic irq,
  output logic ovf_event,
  output logic [timer_core_pkg::CHANNELS-1:0] cmp_event
);
  import timer_core_pkg::*;

  // Configuration state.
  logic enable; // Counter runs while set.
  logic [2:0] clock_select; // Prescaler choice.
  logic [2:0] wave_mode; // Waveform mode code.
  logic [CHANNELS-1:0] compare_output_enable; // Per-channel pin takeover.
  logic dir_down; // Count direction, one means downward.
  logic lock_update; // Blocks buffer transfers while set.
  logic count_on_event_enable; // Events replace prescaled ticks.
  logic [CHANNELS:0] int_enable; // Interrupt enables, overflow in bit zero.
  logic [CHANNELS:0] int_flags; // Sticky flags, overflow in bit zero.

  // Counting state.
  logic [15:0] counter_value;
  logic [15:0] period_value;
  logic [15:0] period_buffer;
  logic period_buffer_valid;
  logic [15:0] compare_value [CHANNELS];
  logic [15:0] compare_buffer [CHANNELS];
  logic [CHANNELS-1:0] compare_buffer_valid;
  logic [CHANNELS-1:0] wave; // Waveform generator levels.

  // Next values.
  logic next_enable;
  logic [2:0] next_clock_select;
  logic [2:0] next_wave_mode;
  logic [CHANNELS-1:0] next_compare_output_enable;
  logic next_dir_down;
  logic next_lock_update;
  logic next_count_on_event_enable;
  logic [CHANNELS:0] next_int_enable;
  logic [CHANNELS:0] next_int_flags;
  logic [15:0] next_counter_value;
  logic [15:0] next_period_value;
  logic [15:0] next_period_buffer;
  logic next_period_buffer_valid;
  logic [15:0] next_compare_value [CHANNELS];
  logic [15:0] next_compare_buffer [CHANNELS];
  logic [CHANNELS-1:0] next_compare_buffer_valid;
  logic [CHANNELS-1:0] next_wave;
  logic [15:0] next_rdata;
  logic [CHANNELS-1:0] next_pin_out;
  logic [CHANNELS-1:0] next_pin_override;
  logic next_irq;
  logic next_ovf_event;
  logic [CHANNELS-1:0] next_cmp_event;

  // Combinational helpers.
  logic tick; // One timer tick, from the tick source.
  logic [15:0] ceiling; // Top of the present sequence.
  logic at_zero; // Counter sits at the zero point.
  logic at_ceiling; // Counter sits at the ceiling.
  logic at_max; // Counter holds all ones.
  logic update_point; // Buffer transfer moment on this tick.
  logic wave_on; // A waveform mode is selected.
  logic [CHANNELS-1:0] match; // Counter equals each compare_value.

  // Prescaled clock or synchronised events become the timer tick.
  timer_tick_source tick_source (
    .clk(clk),
    .nrst(nrst),
    .run(enable),
    .clock_select(clock_select),
    .count_on_event_enable(count_on_event_enable),
    .event_in(event_in),
    .tick(tick)
  );

  // Address match for a channel register, given the channel's base index.
  function automatic logic hits(input logic [3:0] a, input logic [3:0] base, input int ch);
    hits = (a == base + ch[3:0]);
  endfunction : hits

  // Sequence points seen by the comparators.
  always_comb begin
    // In frequency mode the first compare sets the ceiling, else the period does.
    ceiling = (wave_mode == WAVE_FREQUENCY) ? compare_value[0] : period_value;
    at_zero = (counter_value == ZERO16);
    at_max = (counter_value == ALL_ONES16);
    at_ceiling = (counter_value == ceiling);
    wave_on = (wave_mode != WAVE_NORMAL);
    // Dual slope updates at the zero point, the others at the wrap point.
    if (wave_mode == WAVE_DUAL_SLOPE) begin
      update_point = at_zero;
    end else begin
      update_point = dir_down ? at_zero : at_ceiling;
    end
    for (int ch = 0; ch < CHANNELS; ch++) begin
      match[ch] = (counter_value == compare_value[ch]);
    end
  end

  // Next state of the counter, buffers, flags and waveforms.
  always_comb begin
    next_enable = enable;
    next_clock_select = clock_select;
    next_wave_mode = wave_mode;
    next_compare_output_enable = compare_output_enable;
    next_dir_down = dir_down;
    next_lock_update = lock_update;
    next_count_on_event_enable = count_on_event_enable;
    next_int_enable = int_enable;
    next_int_flags = int_flags;
    next_counter_value = counter_value;
    next_period_value = period_value;
    next_period_buffer = period_buffer;
    next_period_buffer_valid = period_buffer_valid;
    next_compare_value = compare_value;
    next_compare_buffer = compare_buffer;
    next_compare_buffer_valid = compare_buffer_valid;
    next_wave = wave;
    next_ovf_event = 1'b0;
    next_cmp_event = '0;

    // Counter writes are decoded further down and override whatever is chosen here.
    // Counting happens only on a tick, and the tick only runs while enabled.
    if (tick && enable) begin
      if (wave_mode == WAVE_DUAL_SLOPE) begin
        // Dual slope turns round at the ceiling and at the zero point.
        if (!dir_down && at_ceiling) begin
          next_dir_down = 1'b1;
          next_counter_value = counter_value - 16'h0001;
        end else if (dir_down && at_zero) begin
          next_dir_down = 1'b0;
          next_counter_value = counter_value + 16'h0001;
        end else begin
          next_counter_value = dir_down ? counter_value - 16'h0001 : counter_value + 16'h0001;
        end
      end else if (!dir_down) begin
        // Only exact equality wraps, so a period below the count runs on past all ones.
        next_counter_value = at_ceiling ? ZERO16 : counter_value + 16'h0001;
      end else begin
        next_counter_value = at_zero ? ceiling : counter_value - 16'h0001;
      end
      // Sequence end raises the overflow flag and event one tick after it was reached.
      if (update_point) begin
        next_int_flags[OVERFLOW_FLAG_BIT] = 1'b1;
        next_ovf_event = 1'b1;
      end
      // Compare matches seen on the previous count act on this tick.
      for (int ch = 0; ch < CHANNELS; ch++) begin
        if (match[ch]) begin
          next_int_flags[COMPARE_FLAG_LSB + ch] = 1'b1;
          next_cmp_event[ch] = 1'b1;
        end
        case (wave_mode)
          WAVE_FREQUENCY: begin
            if (match[ch]) begin
              next_wave[ch] = !wave[ch];
            end
          end
          WAVE_SINGLE_SLOPE: begin
            // Cleared on match, set when the count restarts from zero.
            if (match[ch]) begin
              next_wave[ch] = 1'b0;
            end else if (at_ceiling) begin
              next_wave[ch] = 1'b1;
            end
          end
          WAVE_DUAL_SLOPE: begin
            // Cleared on an upward match, set on a downward match and at zero.
            if (match[ch]) begin
              next_wave[ch] = dir_down;
            end else if (at_zero) begin
              next_wave[ch] = 1'b1;
            end
          end
          default: begin
            next_wave[ch] = 1'b0;
          end
        endcase
      end
      // Valid buffers move into the working registers unless the update is locked.
      if (update_point && !lock_update) begin
        if (period_buffer_valid) begin
          next_period_value = period_buffer;
          next_period_buffer_valid = 1'b0;
        end
        for (int ch = 0; ch < CHANNELS; ch++) begin
          if (compare_buffer_valid[ch]) begin
            next_compare_value[ch] = compare_buffer[ch];
            next_compare_buffer_valid[ch] = 1'b0;
          end
        end
      end
    end

    // Software writes come last so they win over a simultaneous hardware change, except a flag being set in that cycle.
    if (wr) begin
      if (addr == ADDR_CONTROL_A) begin
        next_enable = wdata[ENABLE_BIT];
        next_clock_select = wdata[CLOCK_SELECT_LSB +: 3];
      end else if (addr == ADDR_CONTROL_B) begin
        next_wave_mode = wdata[2:0];
        next_compare_output_enable = wdata[COMPARE_ENABLE_LSB +: CHANNELS];
      end else if (addr == ADDR_CONTROL_E) begin
        next_dir_down = wdata[DIR_BIT];
        next_lock_update = wdata[LOCK_UPDATE_BIT];
      end else if (addr == ADDR_EVENT_CONTROL) begin
        next_count_on_event_enable = wdata[COUNT_EVENT_BIT];
      end else if (addr == ADDR_INT_CONTROL) begin
        next_int_enable = wdata[CHANNELS:0];
      end else if (addr == ADDR_INT_FLAGS) begin
        // Write one to clear; a flag set in this same cycle stays set.
        next_int_flags = (int_flags & ~wdata[CHANNELS:0]) | (next_int_flags & ~int_flags);
      end else if (addr == ADDR_COUNTER) begin
        next_counter_value = wdata;
      end else if (addr == ADDR_PERIOD) begin
        next_period_value = wdata;
      end else if (addr == ADDR_PERIOD_BUFFER) begin
        next_period_buffer = wdata;
        next_period_buffer_valid = 1'b1;
      end else begin
        for (int ch = 0; ch < CHANNELS; ch++) begin
          if (hits(addr, ADDR_COMPARE0, ch)) begin
            next_compare_value[ch] = wdata;
          end else if (hits(addr, ADDR_COMPARE_BUFFER0, ch)) begin
            next_compare_buffer[ch] = wdata;
            next_compare_buffer_valid[ch] = 1'b1;
          end
        end
      end
    end
  end

  // Pin override, interrupt line and read data, all registered.
  always_comb begin
    for (int ch = 0; ch < CHANNELS; ch++) begin
      // The waveform replaces the port value only with a mode and the channel enable.
      next_pin_override[ch] = wave_on && compare_output_enable[ch];
      next_pin_out[ch] = next_pin_override[ch] ? wave[ch] : port_out_value[ch];
    end
    next_irq = |(int_flags & int_enable);
    next_rdata = ZERO16;
    if (rd) begin
      if (addr == ADDR_CONTROL_A) begin
        next_rdata = {12'h000, clock_select, enable};
      end else if (addr == ADDR_CONTROL_B) begin
        next_rdata = {9'h000, compare_output_enable, 1'b0, wave_mode};
      end else if (addr == ADDR_CONTROL_E) begin
        next_rdata = {14'h0000, lock_update, dir_down};
      end else if (addr == ADDR_CONTROL_F) begin
        next_rdata = {12'h000, compare_buffer_valid, period_buffer_valid};
      end else if (addr == ADDR_EVENT_CONTROL) begin
        next_rdata = {15'h0000, count_on_event_enable};
      end else if (addr == ADDR_INT_CONTROL) begin
        next_rdata = {12'h000, int_enable};
      end else if (addr == ADDR_INT_FLAGS) begin
        next_rdata = {12'h000, int_flags};
      end else if (addr == ADDR_COUNTER) begin
        next_rdata = counter_value;
      end else if (addr == ADDR_PERIOD) begin
        next_rdata = period_value;
      end else if (addr == ADDR_PERIOD_BUFFER) begin
        next_rdata = period_buffer;
      end else begin
        // Unmapped indices read as zero.
        for (int ch = 0; ch < CHANNELS; ch++) begin
          if (hits(addr, ADDR_COMPARE0, ch)) begin
            next_rdata = compare_value[ch];
          end else if (hits(addr, ADDR_COMPARE_BUFFER0, ch)) begin
            next_rdata = compare_buffer[ch];
          end
        end
      end
    end
  end

  // State registers; nothing but storage here.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enable <= 1'b0;
      clock_select <= 3'h0;
      wave_mode <= WAVE_NORMAL;
      compare_output_enable <= '0;
      dir_down <= 1'b0;
      lock_update <= 1'b0;
      count_on_event_enable <= 1'b0;
      int_enable <= '0;
      int_flags <= '0;
      counter_value <= ZERO16;
      period_value <= PERIOD_RESET;
      period_buffer <= PERIOD_RESET;
      period_buffer_valid <= 1'b0;
      for (int ch = 0; ch < CHANNELS; ch++) begin
        compare_value[ch] <= ZERO16;
        compare_buffer[ch] <= ZERO16;
      end
      compare_buffer_valid <= '0;
      wave <= '0;
      rdata <= ZERO16;
      pin_out <= '0;
      pin_override <= '0;
      irq <= 1'b0;
      ovf_event <= 1'b0;
      cmp_event <= '0;
    end else begin
      enable <= next_enable;
      clock_select <= next_clock_select;
      wave_mode <= next_wave_mode;
      compare_output_enable <= next_compare_output_enable;
      dir_down <= next_dir_down;
      lock_update <= next_lock_update;
      count_on_event_enable <= next_count_on_event_enable;
      int_enable <= next_int_enable;
      int_flags <= next_int_flags;
      counter_value <= next_counter_value;
      period_value <= next_period_value;
      period_buffer <= next_period_buffer;
      period_buffer_valid <= next_period_buffer_valid;
      compare_value <= next_compare_value;
      compare_buffer <= next_compare_buffer;
      compare_buffer_valid <= next_compare_buffer_valid;
      wave <= next_wave;
      rdata <= next_rdata;
      pin_out <= next_pin_out;
      pin_override <= next_pin_override;
      irq <= next_irq;
      ovf_event <= next_ovf_event;
      cmp_event <= next_cmp_event;
    end
  end

endmodule : buffered_compare_timer_core

/* File: src/timer_core_pkg.sv */
// Constants, register map and mode encodings for the buffered compare timer.
// Assumes a plain single-cycle register port and one 40 MHz peripheral clock.
package timer_core_pkg;

  localparam int CNT_W = 16;
  localparam int CHANNELS = 3;
  localparam int ADDR_W = 4;

  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_CONTROL_A = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_B = 4'h1;
  localparam logic [3:0] ADDR_CONTROL_E = 4'h2;
  localparam logic [3:0] ADDR_CONTROL_F = 4'h3;
  localparam logic [3:0] ADDR_EVENT_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_INT_CONTROL = 4'h5;
  localparam logic [3:0] ADDR_INT_FLAGS = 4'h6;
  localparam logic [3:0] ADDR_COUNTER = 4'h7;
  localparam logic [3:0] ADDR_PERIOD = 4'h8;
  localparam logic [3:0] ADDR_PERIOD_BUFFER = 4'h9;
  localparam logic [3:0] ADDR_COMPARE0 = 4'hA;
  localparam logic [3:0] ADDR_COMPARE_BUFFER0 = 4'hD;

  // Field positions.
  localparam int ENABLE_BIT = 0;
  localparam int CLOCK_SELECT_LSB = 1;
  localparam int COMPARE_ENABLE_LSB = 4;
  localparam int DIR_BIT = 0;
  localparam int LOCK_UPDATE_BIT = 1;
  localparam int COUNT_EVENT_BIT = 0;
  localparam int OVERFLOW_FLAG_BIT = 0;
  localparam int COMPARE_FLAG_LSB = 1;

  // Reset values.
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] ALL_ONES16 = 16'hFFFF;

  // Waveform modes.
  typedef enum logic [2:0] {
    WAVE_NORMAL = 3'b000,
    WAVE_FREQUENCY = 3'b001,
    WAVE_SINGLE_SLOPE = 3'b011,
    WAVE_DUAL_SLOPE = 3'b101
  } wave_mode_t;

endpackage : timer_core_pkg

/* File: src/timer_tick_source.sv */
// Tick generator: prescaler over the peripheral clock and an event input path.
// Assumes event_in is asynchronous to clk and changes slower than clk.
`timescale 1ns/1ps
module timer_tick_source (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic [2:0] clock_select,
  input wire logic count_on_event_enable,
  input wire logic event_in,
  output logic tick
);
  import timer_core_pkg::*;

  logic [9:0] prescale_count; // Free running prescaler while enabled.
  logic [9:0] next_prescale_count;
  logic event_meta; // First synchroniser stage, read only by event_sync.
  logic event_sync; // Second synchroniser stage.
  logic event_last; // Previous synchronised level for edge detection.
  logic next_tick;

  // Divider mask for each clock_select code: divide by 1,2,4,8,16,64,256,1024.
  function automatic logic [9:0] divide_mask(input logic [2:0] sel);
    case (sel)
      3'h0: divide_mask = 10'h000;
      3'h1: divide_mask = 10'h001;
      3'h2: divide_mask = 10'h003;
      3'h3: divide_mask = 10'h007;
      3'h4: divide_mask = 10'h00F;
      3'h5: divide_mask = 10'h03F;
      3'h6: divide_mask = 10'h0FF;
      default: divide_mask = 10'h3FF;
    endcase
  endfunction : divide_mask

  // The prescaler is held at zero while stopped so the first tick has a fixed delay.
  always_comb begin
    next_prescale_count = run ? prescale_count + 10'h001 : 10'h000;
    if (count_on_event_enable) begin
      next_tick = run && event_sync && !event_last;
    end else begin
      next_tick = run && ((prescale_count & divide_mask(clock_select)) == 10'h000);
    end
  end

  // Registers only; the tick is a one-cycle pulse, except at divide by 1 where it stays high while running.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prescale_count <= 10'h000;
      event_meta <= 1'b0;
      event_sync <= 1'b0;
      event_last <= 1'b0;
      tick <= 1'b0;
    end else begin
      prescale_count <= next_prescale_count;
      event_meta <= event_in;
      event_sync <= event_meta;
      event_last <= event_sync;
      tick <= next_tick;
    end
  end

endmodule : timer_tick_source

/* File: test/timer_core_properties.sv */
// Port checker for the buffered compare timer core.
// Assumes it sees only the core's ports; control fields are shadowed from writes.
`timescale 1ns/1ps
module timer_core_properties
  import timer_core_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [timer_core_pkg::ADDR_W-1:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic [timer_core_pkg::CHANNELS-1:0] port_out_value,
  input wire logic [timer_core_pkg::CHANNELS-1:0] pin_out,
  input wire logic [timer_core_pkg::CHANNELS-1:0] pin_override,
  input wire logic irq,
  input wire logic ovf_event,
  input wire logic [timer_core_pkg::CHANNELS-1:0] cmp_event
);
  logic en; // Shadow of the enable bit.
  logic evc; // Shadow of count on event.
  logic [2:0] csel, mode, ce; // Shadow of prescaler, mode and channel enables.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // The shadows follow register writes, so they match the core once a write lands.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {en, csel, evc, mode, ce} <= '0;
    end else if (wr && addr == ADDR_CONTROL_A) begin
      {csel, en} <= wdata[3:0];
    end else if (wr && addr == ADDR_CONTROL_B) begin
      {ce, mode} <= {wdata[6:4], wdata[2:0]};
    end else if (wr && addr == ADDR_EVENT_CONTROL) begin
      evc <= wdata[0];
    end
  end
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data present without a read");
  AST_DISABLED_QUIET: assert property ((!en)[*4] |-> !ovf_event && cmp_event == '0)
    else $error("event while the counter is disabled");
  AST_OVERRIDE: assert property (!$past(wr) && !$past(wr, 2) && mode inside {3'h0, 3'h1, 3'h3, 3'h5}
    |-> pin_override == (mode == 3'h0 ? 3'h0 : ce)) else $error("pin override wrong");
  AST_PIN_PASS: assert property ($past(nrst) |->
    ((pin_out ^ $past(port_out_value)) & ~pin_override & ~$past(pin_override)) == '0)
    else $error("pin does not follow port value");
  AST_OVF_SPACING: assert property (ovf_event && en && !evc && csel == 3'h2 && !wr
    |=> (!ovf_event)[*3]) else $error("overflow faster than the prescaler");
  AST_CMP_SPACING: assert property ($rose(cmp_event[0]) && en && !evc && csel == 3'h3
    |=> (cmp_event[0] == 1'b0)[*7]) else $error("match faster than the prescaler");
  AST_IRQ_RISE: assert property ($rose(irq) |-> ovf_event || (|cmp_event)
    || $past(ovf_event || (|cmp_event) || wr) || $past(ovf_event || (|cmp_event) || wr, 2))
    else $error("interrupt without a cause");
  AST_IRQ_FALL: assert property ($fell(irq) |-> $past(wr) || $past(wr, 2))
    else $error("interrupt dropped without a write");
  COV_OVF: cover property (ovf_event);
  COV_CMP: cover property (|cmp_event);
  COV_IRQ: cover property ($rose(irq));
  COV_PIN: cover property (|pin_override);
endmodule : timer_core_properties

bind buffered_compare_timer_core timer_core_properties i_props (.clk(clk), .nrst(nrst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .port_out_value(port_out_value),
  .pin_out(pin_out), .pin_override(pin_override), .irq(irq), .ovf_event(ovf_event),
  .cmp_event(cmp_event));

/* File: test/testbench.sv */
// Self-checking bench for the buffered compare timer core with a counting model.
// Assumes the package, the core and its checker are compiled first.
`timescale 1ns/1ps
module testbench;
  import timer_core_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [15:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic event_in = 1'b0;
  logic [CHANNELS-1:0] port_out_value = '0;
  logic [CHANNELS-1:0] pv_d = '0; // Port value the pins should show now.
  logic [CHANNELS-1:0] pin_out, pin_override, cmp_event, ce;
  logic [15:0] rdata;
  logic irq, ovf_event;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_ovf = 0;
  int n_cmp = 0;
  int g;
  // Model state: counter, period, compares, buffers and flags.
  int cnt = 0, per = 65535, pbuf = 0, pbv = 0, cmp0 = 0, cmp1 = 0, cbuf1 = 0, cbv1 = 0;
  int flags = 0, e_ovf = 0, e_cmp = 0, down = 0, lock = 0, en = 0;
  wave_mode_t modes [4] = '{WAVE_NORMAL, WAVE_FREQUENCY, WAVE_SINGLE_SLOPE, WAVE_DUAL_SLOPE};
  always #12.5 clk = ~clk;
  buffered_compare_timer_core i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .event_in(event_in), .port_out_value(port_out_value),
    .pin_out(pin_out), .pin_override(pin_override), .irq(irq), .ovf_event(ovf_event),
    .cmp_event(cmp_event));
  // Random pin data, pulse counters and the run limit.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    pv_d <= port_out_value;
    port_out_value <= CHANNELS'($urandom);
    n_ovf <= n_ovf + int'(ovf_event);
    n_cmp <= n_cmp + $countones(cmp_event);
    if (cycles == 30000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, exp);
  endtask : rreg
  // Each event is held long enough to pass the input synchroniser.
  task automatic pulse(input int n);
    int was;
    repeat (n) begin
      @(posedge clk) event_in <= 1'b1;
      repeat (4) @(posedge clk);
      event_in <= 1'b0;
      repeat (4) @(posedge clk);
      was = cnt;
      if (en) begin
        e_cmp += int'(cmp0 == was) + int'(cmp1 == was) + int'(was == 0);
        flags |= (cmp0 == was ? 2 : 0) | (cmp1 == was ? 4 : 0) | (was == 0 ? 8 : 0);
        cnt = (!down && (was == per || was == 65535)) ? 0 : (down && was == 0) ? per
          : (down ? was - 1 : was + 1);
        if (down ? was == 0 : was == per) begin
          e_ovf++;
          flags |= 1;
          if (!lock && pbv) {per, pbv} = {pbuf, 32'd0};
          if (!lock && cbv1) {cmp1, cbv1} = {cbuf1, 32'd0};
        end
      end
    end
    repeat (6) @(posedge clk);
  endtask : pulse
  task automatic gap(output int c);
    int i;
    i = 0;
    c = 0;
    @(negedge clk);
    while (ovf_event !== 1'b1 && i < 400) begin
      @(negedge clk);
      i++;
    end
    do begin
      @(negedge clk);
      c++;
    end while (ovf_event !== 1'b1 && c < 400);
  endtask : gap
  task automatic conclude();
    $display("errors %0d, comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    void'($urandom(35));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (int a = 0; a < 16; a++) rreg(4'(a), (a == 8 || a == 9) ? 16'hFFFF : 16'h0000);
    wreg(ADDR_CONTROL_F, 16'hFFFF);
    rreg(ADDR_CONTROL_F, 16'h0000);
    wreg(ADDR_EVENT_CONTROL, 16'h0001);
    wreg(ADDR_PERIOD, 16'h0005);
    per = 5;
    wreg(ADDR_COUNTER, 16'h0002);
    cnt = 2;
    pulse(3);
    rreg(ADDR_COUNTER, 16'(cnt));
    wreg(ADDR_COMPARE0, 16'h0004);
    cmp0 = 4;
    wreg(ADDR_INT_CONTROL, 16'h0001);
    wreg(ADDR_CONTROL_A, 16'h0001);
    en = 1;
    pulse(3);
    wreg(ADDR_PERIOD_BUFFER, 16'h0003);
    {pbuf, pbv} = {32'd3, 32'd1};
    wreg(4'hE, 16'h0002);
    {cbuf1, cbv1} = {32'd2, 32'd1};
    rreg(ADDR_CONTROL_F, 16'h0005);
    pulse(6 + $urandom_range(4));
    rreg(ADDR_COUNTER, 16'(cnt));
    rreg(ADDR_PERIOD, 16'(per));
    rreg(4'hB, 16'(cmp1));
    rreg(ADDR_CONTROL_F, 16'(pbv | cbv1 << 2));
    rreg(ADDR_INT_FLAGS, 16'(flags));
    chk(16'(irq), 16'(flags & 1));
    wreg(ADDR_INT_FLAGS, 16'h000F);
    repeat (3) @(negedge clk);
    chk(16'(irq), 16'h0000);
    wreg(ADDR_CONTROL_E, 16'h0002);
    lock = 1;
    wreg(ADDR_PERIOD_BUFFER, 16'h0007);
    {pbuf, pbv} = {32'd7, 32'd1};
    pulse(5);
    rreg(ADDR_PERIOD, 16'(per));
    wreg(ADDR_CONTROL_E, 16'h0000);
    lock = 0;
    pulse(5);
    rreg(ADDR_PERIOD, 16'(per));
    chk(16'(n_ovf), 16'(e_ovf));
    chk(16'(n_cmp), 16'(e_cmp));
    wreg(ADDR_CONTROL_E, 16'h0001);
    down = 1;
    pulse(12);
    rreg(ADDR_COUNTER, 16'(cnt));
    wreg(ADDR_CONTROL_E, 16'h0000);
    down = 0;
    wreg(ADDR_PERIOD, 16'h0002);
    per = 2;
    wreg(ADDR_COUNTER, 16'hFFFD);
    cnt = 65533;
    pulse(6);
    rreg(ADDR_COUNTER, 16'(cnt));
    wreg(ADDR_EVENT_CONTROL, 16'h0000);
    wreg(ADDR_PERIOD, 16'h0003);
    wreg(ADDR_COMPARE0, 16'h0001);
    for (int s = 0; s < 4; s++) begin
      wreg(ADDR_CONTROL_A, 16'(1 + 2 * s));
      repeat (40) @(posedge clk);
      gap(g);
      chk(16'(g), 16'(4 << s));
    end
    wreg(ADDR_CONTROL_A, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      ce = CHANNELS'($urandom);
      wreg(ADDR_CONTROL_B, {9'h000, ce, 1'b0, modes[m]});
      repeat (3) @(negedge clk);
      chk(16'(pin_override), 16'(m == 0 ? 3'h0 : ce));
      chk(16'(pin_out & ~pin_override), 16'(pv_d & ~pin_override));
    end
    // Frequency mode: compare 0 sets the ceiling, channel 0 toggles once per sequence.
    wreg(ADDR_CONTROL_B, 16'h0011);
    wreg(ADDR_COMPARE0, 16'h0003);
    wreg(ADDR_CONTROL_A, 16'h0001);
    gap(g);
    chk(16'(g), 16'h0004);
    @(negedge clk);
    g = int'(pin_out[0]);
    chk(16'(pin_override), 16'h0001);
    repeat (4) @(negedge clk);
    chk(16'(pin_out[0]), 16'(g ^ 1));
    conclude();
  end
endmodule : testbench
